// ===== rtl/bst_regs.svh
// constant names for the boundary-scan tap block
`ifndef BST_REGS_SVH
`define BST_REGS_SVH
`define BST_IR_LEN 10
`define BST_CELL_BITS 3
`define BST_CELL_OUT 0
`define BST_CELL_OE 1
`define BST_CELL_IN 2
`define BST_IR_BYPASS 10'h03FF
`define BST_IR_SAMPLE 10'h0005
`define BST_IR_EXTEST 10'h000F
`define BST_IR_IDCODE 10'h0006
`define BST_IR_USERCODE 10'h0007
`define BST_IR_CLAMP 10'h000A
`define BST_IR_HIGHZ 10'h000B
`define BST_IR_CAPTURE 10'h0001
`define BST_RESET_ONES 3'h5
`endif

// ===== rtl/bst_pkg.sv
// types shared by the boundary-scan tap block
package bst_pkg;
    // sixteen tap controller states
    typedef enum logic [3:0] {
        BST_RESET, BST_IDLE, BST_SEL_DR, BST_CAP_DR, BST_SHIFT_DR, BST_EXIT1_DR,
        BST_PAUSE_DR, BST_EXIT2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SHIFT_IR,
        BST_EXIT1_IR, BST_PAUSE_IR, BST_EXIT2_IR, BST_UPD_IR
    } bst_state_e;
    // the four-wire serial link, device view
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_link_s;
    // common controls to all scan cells
    typedef struct packed {
        logic shift;
        logic capture;
        logic update;
        logic mode;
        logic highz;
        logic rst;
    } bst_ctl_s;
endpackage : bst_pkg

// ===== rtl/bst_cell_chain.sv
// chain of three-bit scan cells, one per user pin
`timescale 1ns/1ps
`default_nettype none
`include "bst_regs.svh"
module bst_cell_chain
    import bst_pkg::*;
#(
    parameter int NPINS = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire bst_ctl_s i_ctl,
    input wire logic i_cell_serial_in,
    input wire logic [NPINS-1:0] i_core_output_value,
    input wire logic [NPINS-1:0] i_core_output_enable,
    input wire logic [NPINS-1:0] i_pad_in,
    output logic o_cell_serial_out,
    output logic [NPINS-1:0] o_pad_out,
    output logic [NPINS-1:0] o_pad_oe
);
    localparam int LEN = NPINS * `BST_CELL_BITS;
    // all state in one struct
    typedef struct packed {
        logic [LEN-1:0] cap;
        logic [NPINS-1:0] upd_out;
        logic [NPINS-1:0] upd_oe;
        logic [NPINS-1:0] pad_out;
        logic [NPINS-1:0] pad_oe;
        logic [NPINS-1:0] pad_s1; // first sync stage of pad levels
        logic [NPINS-1:0] pad_s2; // synchronised pad levels
    } bst_chain_s;
    bst_chain_s st_q;
    bst_chain_s st_d;
    logic [LEN-1:0] live; // captured live signals
    genvar g;
    // each cell: out, oe, input captures; index 0 nearest serial out
    generate
        for (g = 0; g < NPINS; g++)
        begin : g_cell
            assign live[g*`BST_CELL_BITS+`BST_CELL_OUT] = i_core_output_value[g]; // RQ4
            assign live[g*`BST_CELL_BITS+`BST_CELL_OE] = i_core_output_enable[g]; // RQ4
            assign live[g*`BST_CELL_BITS+`BST_CELL_IN] = st_q.pad_s2[g]; // RQ4 RQ3
        end
    endgenerate
    // next state of capture, update and pad stages
    always_comb
    begin
        st_d = st_q;
        // pad levels are asynchronous: two flops before capture
        st_d.pad_s1 = i_pad_in;
        st_d.pad_s2 = st_q.pad_s1;
        if (i_ctl.capture)
        begin
            st_d.cap = live; // RQ16
        end
        else if (i_ctl.shift)
        begin
            // new bit enters far end, oldest leaves first
            st_d.cap = {i_cell_serial_in, st_q.cap[LEN-1:1]}; // RQ2 RQ6 RQ17 RQ21
        end
        if (i_ctl.update)
        begin
            for (int i = 0; i < NPINS; i++)
            begin
                st_d.upd_out[i] = st_q.cap[i*`BST_CELL_BITS+`BST_CELL_OUT]; // RQ18
                st_d.upd_oe[i] = st_q.cap[i*`BST_CELL_BITS+`BST_CELL_OE]; // RQ18
            end
        end
        // pad mux: core path unless highz or test mode selected
        if (i_ctl.highz)
        begin
            st_d.pad_out = '0;
            st_d.pad_oe = '0;
        end
        else if (i_ctl.mode)
        begin
            st_d.pad_out = st_q.upd_out; // RQ4
            st_d.pad_oe = st_q.upd_oe;
        end
        else
        begin
            st_d.pad_out = i_core_output_value; // RQ16
            st_d.pad_oe = i_core_output_enable;
        end
        if (i_ctl.rst)
        begin
            st_d.upd_out = '0;
            st_d.upd_oe = '0;
        end
    end
    // state register
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
    assign o_cell_serial_out = st_q.cap[0];
    assign o_pad_out = st_q.pad_out;
    assign o_pad_oe = st_q.pad_oe;
endmodule : bst_cell_chain
`default_nettype wire

// ===== rtl/bst_tap.sv
// boundary-scan test access port: controller, instruction, bypass, chain
// Notes on behaviour
// (RQ1) one-bit bypass register, shortest path
// (RQ2) boundary chain of three-bit cells
// (RQ3) cells on all user pins, clocks included
// (RQ4) capture out/oe/pad, update drives pad
// (RQ5) common shift/clock/update; decode gives mode
// (RQ6) cells chained serial in to out
// (RQ7) ten-bit instruction register, seven instructions
// (RQ8) sixteen states, tms on rising tck
// (RQ9) reset state: inactive, idcode loaded
// (RQ10) power-up starts in reset state
// (RQ11) five tms highs force reset
// (RQ12) tester uses 01100 to shift-ir
// (RQ13) tdo driven only in shift states
// (RQ14) shift-ir outputs present instruction contents
// (RQ15) tester raises tms with last bit
// (RQ16) sample capture keeps core driving pins
// (RQ17) shift: captured out, new in
// (RQ18) update copies capture into update stages
// (RQ19) capture-dr then shift-dr while tms low
// (RQ20) two tms highs reach update-dr
// (RQ21) new bits follow every captured bit
// (RQ22) sample rising tck, change falling tck
// (RQ23) all ones selects bypass
// (RQ24) standard sixteen-state diagram transitions
// (RQ25) chain length is three per pin
`timescale 1ns/1ps
`default_nettype none
`include "bst_regs.svh"
module bst_tap
    import bst_pkg::*;
#(
    parameter int NPINS = 4 // chain length is 3*NPINS
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    input wire logic [NPINS-1:0] i_core_output_value,
    input wire logic [NPINS-1:0] i_core_output_enable,
    input wire logic [NPINS-1:0] i_pad_in,
    output logic [NPINS-1:0] o_pad_out,
    output logic [NPINS-1:0] o_pad_oe,
    output logic o_test_active
);
    // all tap state in one struct
    typedef struct packed {
        bst_link_s s1;  // first sync stage, read only by s2
        bst_link_s s2;  // synchronised link
        logic tck_prev; // last sampled clock level
        bst_state_e st;
        logic [`BST_IR_LEN-1:0] ir_sh; // instruction shift stage
        logic [`BST_IR_LEN-1:0] ir;    // current instruction
        logic byp;
        logic tdo;
        logic tdo_oe;
        logic active;
    } bst_tap_s;
    bst_tap_s q;
    bst_tap_s d;
    logic rise; // rising tck seen this cycle
    logic fall; // falling tck seen this cycle
    logic chain_out;
    logic sel_bypass;
    logic sel_chain;
    bst_ctl_s ctl;
    // edges come from the synchronised copy only
    // the raw pin is never read here: it may move at any time
    assign rise = q.s2.tck && !q.tck_prev; // RQ22
    assign fall = !q.s2.tck && q.tck_prev; // RQ22
    // instruction decode: unknown codes fall back to bypass
    always_comb
    begin
        sel_chain = 1'b0;
        case (q.ir) // RQ7
            `BST_IR_SAMPLE:
            begin
                // snapshot and preload both go through the chain
                sel_chain = 1'b1;
            end
            `BST_IR_EXTEST:
            begin
                // pins forced from update stages, chain still the serial path
                sel_chain = 1'b1;
            end
            default:
            begin
                // identity, clamp, highz and unknown codes take bypass
                sel_chain = 1'b0;
            end
        endcase
        sel_bypass = !sel_chain; // RQ23 RQ1
    end
    // common controls: shift, capture and update qualified by the rising edge, mode, highz and rst not
    always_comb
    begin
        ctl.shift = rise && (q.st == BST_SHIFT_DR) && sel_chain; // RQ5 RQ17
        ctl.capture = rise && (q.st == BST_CAP_DR) && sel_chain; // RQ5 RQ16
        ctl.update = rise && (q.st == BST_UPD_DR) && sel_chain; // RQ5 RQ18
        ctl.mode = (q.ir == `BST_IR_EXTEST) || (q.ir == `BST_IR_CLAMP); // RQ5
        ctl.highz = (q.ir == `BST_IR_HIGHZ);
        // pins run normally in the reset state, whatever instruction is held
        if (q.st == BST_RESET)
        begin
            ctl.mode = 1'b0; // RQ9
            ctl.highz = 1'b0; // RQ9
        end
        ctl.rst = (q.st == BST_RESET); // RQ9
    end
    // next state of controller and registers
    always_comb
    begin
        d = q;
        // link pins enter the two-stage synchroniser
        d.s1 = '{tck: i_tck, tms: i_tms, tdi: i_tdi};
        d.s2 = q.s1;
        // previous clock level, for edge finding
        d.tck_prev = q.s2.tck;
        if (rise)
        begin
            // standard diagram; five tms highs reach reset from anywhere
            case (q.st) // RQ8 RQ24 RQ11
                BST_RESET:
                begin
                    // held here while tms stays high
                    d.st = q.s2.tms ? BST_RESET : BST_IDLE;
                end
                BST_IDLE:
                begin
                    // parked between scans while tms low
                    d.st = q.s2.tms ? BST_SEL_DR : BST_IDLE;
                end
                BST_SEL_DR:
                begin
                    // choose data or instruction column
                    d.st = q.s2.tms ? BST_SEL_IR : BST_CAP_DR;
                end
                BST_CAP_DR:
                begin
                    // capture done, shift or skip to exit
                    d.st = q.s2.tms ? BST_EXIT1_DR : BST_SHIFT_DR; // RQ19
                end
                BST_SHIFT_DR:
                begin
                    // keeps shifting while tms low
                    d.st = q.s2.tms ? BST_EXIT1_DR : BST_SHIFT_DR; // RQ19
                end
                BST_EXIT1_DR:
                begin
                    // second high in a row goes to update
                    d.st = q.s2.tms ? BST_UPD_DR : BST_PAUSE_DR; // RQ20
                end
                BST_PAUSE_DR:
                begin
                    // tester may rest here
                    d.st = q.s2.tms ? BST_EXIT2_DR : BST_PAUSE_DR;
                end
                BST_EXIT2_DR:
                begin
                    // resume shifting or update
                    d.st = q.s2.tms ? BST_UPD_DR : BST_SHIFT_DR;
                end
                BST_UPD_DR:
                begin
                    // update done, next scan or idle
                    d.st = q.s2.tms ? BST_SEL_DR : BST_IDLE;
                end
                BST_SEL_IR:
                begin
                    // a further high lands in reset
                    d.st = q.s2.tms ? BST_RESET : BST_CAP_IR;
                end
                BST_CAP_IR:
                begin
                    // present instruction loaded for shifting
                    d.st = q.s2.tms ? BST_EXIT1_IR : BST_SHIFT_IR;
                end
                BST_SHIFT_IR:
                begin
                    // keeps shifting while tms low
                    d.st = q.s2.tms ? BST_EXIT1_IR : BST_SHIFT_IR; // RQ14
                end
                BST_EXIT1_IR:
                begin
                    // high goes to update
                    d.st = q.s2.tms ? BST_UPD_IR : BST_PAUSE_IR;
                end
                BST_PAUSE_IR:
                begin
                    // tester may rest here
                    d.st = q.s2.tms ? BST_EXIT2_IR : BST_PAUSE_IR;
                end
                BST_EXIT2_IR:
                begin
                    // resume shifting or update
                    d.st = q.s2.tms ? BST_UPD_IR : BST_SHIFT_IR;
                end
                BST_UPD_IR:
                begin
                    // new instruction in force from the next state on
                    d.st = q.s2.tms ? BST_SEL_DR : BST_IDLE;
                end
                default:
                begin
                    // unreachable codes recover through reset
                    d.st = BST_RESET;
                end
            endcase
            case (q.st)
                BST_RESET:
                begin
                    // reload the power-up instruction on every rise here
                    d.ir = `BST_IR_IDCODE; // RQ9
                end
                BST_CAP_IR:
                begin
                    // capture loads present instruction for shifting out
                    d.ir_sh = q.ir; // RQ14
                end
                BST_SHIFT_IR:
                begin
                    // lsb first, tdi sampled on rising edge
                    d.ir_sh = {q.s2.tdi, q.ir_sh[`BST_IR_LEN-1:1]}; // RQ22 RQ7
                end
                BST_UPD_IR:
                begin
                    // decode sees the new code only after update
                    d.ir = q.ir_sh;
                end
                BST_CAP_DR:
                begin
                    // bypass captures a fixed zero
                    d.byp = 1'b0; // RQ1
                end
                BST_SHIFT_DR:
                begin
                    // one-stage path, tdi straight towards tdo
                    d.byp = q.s2.tdi; // RQ1
                end
                default:
                begin
                    // nothing else touches the instruction
                    d.ir = q.ir;
                end
            endcase
        end
        // tdo changes and enables only on falling edges
        // outside shift states tdo keeps its level, only the enable drops
        if (fall)
        begin
            d.tdo_oe = (q.st == BST_SHIFT_IR) || (q.st == BST_SHIFT_DR); // RQ13
            if (q.st == BST_SHIFT_IR)
            begin
                // lsb of the held instruction leads
                d.tdo = q.ir_sh[0]; // RQ14
            end
            else if (q.st == BST_SHIFT_DR)
            begin
                // path chosen by the current instruction
                d.tdo = sel_bypass ? q.byp : chain_out; // RQ1 RQ21
            end
        end
        // status flag lags the state by one clock
        d.active = (q.st != BST_RESET); // RQ9
    end
    // state register; reset is the power-up reset state
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            // every field cleared, then the reset state and its instruction
            q <= '0; // RQ10
            q.st <= BST_RESET; // RQ10
            q.ir <= `BST_IR_IDCODE; // RQ9
        end
        else
        begin
            // plain register transfer
            q <= d;
        end
    end
    // boundary chain, length three per pin
    bst_cell_chain #(
        .NPINS(NPINS) // RQ25
    ) u_chain (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ctl(ctl),
        .i_cell_serial_in(q.s2.tdi),
        .i_core_output_value(i_core_output_value),
        .i_core_output_enable(i_core_output_enable),
        .i_pad_in(i_pad_in),
        .o_cell_serial_out(chain_out),
        .o_pad_out(o_pad_out),
        .o_pad_oe(o_pad_oe)
    );
    // outputs straight from registers, no logic after the flops
    assign o_tdo = q.tdo;
    assign o_tdo_oe = q.tdo_oe;
    assign o_test_active = q.active;
endmodule : bst_tap
`default_nettype wire

// ===== tb/bst_tap_properties.sv
// port assertions for the boundary-scan tap
`timescale 1ns/1ps
`default_nettype none
module bst_tap_properties #(
    parameter int NPINS = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic [NPINS-1:0] i_core_output_value,
    input wire logic [NPINS-1:0] i_core_output_enable,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic [NPINS-1:0] o_pad_out,
    input wire logic [NPINS-1:0] o_pad_oe,
    input wire logic o_test_active
);
    logic [2:0] fall_q; // clocks since tck fell, saturating
    logic [2:0] rise_q; // clocks since tck rose, saturating
    // edge ages tie each output move to the tck edge behind it
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            fall_q <= 3'h7;
            rise_q <= 3'h7;
        end
        else
        begin
            fall_q <= $fell(i_tck) ? 3'h1 : fall_q + 3'(fall_q != 3'h7);
            rise_q <= $rose(i_tck) ? 3'h1 : rise_q + 3'(rise_q != 3'h7);
        end
    end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    rst_quiet_a: assert property ($fell(i_rst) |-> !o_tdo_oe && !o_test_active)
        else $error("tap not quiet after reset");
    pads_follow_a: assert property (!o_test_active [*2] |->
        o_pad_out == $past(i_core_output_value) && o_pad_oe == $past(i_core_output_enable))
        else $error("pads left core path while tap idle");
    oe_at_fall_a: assert property ($changed(o_tdo_oe) |-> fall_q inside {[2:6]})
        else $error("tdo enable moved away from tck fall");
    tdo_at_fall_a: assert property ($changed(o_tdo) |-> fall_q inside {[2:6]})
        else $error("tdo moved away from tck fall");
    step_at_rise_a: assert property ($changed(o_test_active) |-> rise_q inside {[2:6]})
        else $error("state moved away from tck rise");
    leave_rst_a: assert property ($rose(o_test_active) |-> !i_tms)
        else $error("left reset state with tms high");
    enter_rst_a: assert property ($fell(o_test_active) |-> i_tms)
        else $error("entered reset state with tms low");
    oe_active_a: assert property (o_tdo_oe |-> o_test_active)
        else $error("tdo driven in reset state");
    cover property ($rose(o_tdo_oe));
    cover property ($fell(o_test_active));
    cover property (o_test_active && o_pad_out != i_core_output_value);
endmodule : bst_tap_properties
`default_nettype wire

// ===== tb/bst_tester.sv
// serial test controller model driving the four-wire link
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo,
    input wire logic i_tdo_oe
);
    logic last_q; // last level read, inverted when tdo is released
    // tck rests low outside frames, tms and tdi at their pull-up level
    initial
    begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
        last_q = 1'b0;
    end
    // one tck period: set-up, rise, read tdo mid-high, fall
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        #100 o_tms = tms;
        o_tdi = tdi;
        #100 o_tck = 1'b1;
        #100 tdo = i_tdo_oe ? i_tdo : ~last_q;
        last_q = tdo;
        #100 o_tck = 1'b0;
    endtask : step
    // tms pattern, lsb first
    task automatic move(input int n, input logic [31:0] pat);
        logic b;
        for (int i = 0; i < n; i++)
            step(pat[i], 1'b1, b);
    endtask : move
    // shift n bits lsb first, tms raised with the last one
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        dout = '0;
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
    endtask : shift
endmodule : bst_tester
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the boundary-scan tap
`timescale 1ns/1ps
`default_nettype none
`include "bst_regs.svh"
module tb;
    localparam int NP = 4;
    localparam int CL = 3 * NP; // chain length
    logic i_clk, i_rst, tck, tms, tdi, tdo, tdo_oe, act;
    logic [NP-1:0] cval, coe, pin, pout, poe;
    logic [31:0] seed = 32'h0001_38D8;
    logic [31:0] din, d;
    int n_mismatch = 0;
    int samples_checked = 0;
    bst_tap #(.NPINS(NP)) i_bst_tap (.i_clk(i_clk), .i_rst(i_rst), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_core_output_value(cval),
        .i_core_output_enable(coe), .i_pad_in(pin), .o_pad_out(pout), .o_pad_oe(poe),
        .o_test_active(act));
    bst_tester i_bst_tester (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo),
        .i_tdo_oe(tdo_oe));
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // captured chain: per pin out, oe, pad, pin0 nearest tdo
    function automatic logic [CL-1:0] cap_exp(input logic [NP-1:0] v, e, p);
        logic [CL-1:0] r;
        for (int k = 0; k < NP; k++)
            r[3*k +: 3] = {p[k], e[k], v[k]};
        return r;
    endfunction : cap_exp
    // pad drive {out, oe} taken from update stages
    function automatic logic [2*NP-1:0] upd_exp(input logic [CL-1:0] c);
        logic [2*NP-1:0] r;
        for (int k = 0; k < NP; k++)
            {r[NP+k], r[k]} = {c[3*k], c[3*k+1]};
        return r;
    endfunction : upd_exp
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic rnd_core();
        seed = xs(seed);
        {cval, coe, pin} = seed[3*NP-1:0];
    endtask : rnd_core
    // idle to shift-ir, load code, check previous contents, back to idle
    task automatic ir_load(input logic [9:0] code, input logic [9:0] prev);
        logic [31:0] q;
        i_bst_tester.move(4, 32'h0000_0003);
        i_bst_tester.shift(10, 32'(code), q);
        chk(q, 32'(prev), "ir contents");
        i_bst_tester.move(2, 32'h0000_0001);
        chk(32'(tdo_oe), 32'h0000_0000, "tdo released");
    endtask : ir_load
    task automatic dr_scan(input int n, input logic [31:0] di, output logic [31:0] q);
        i_bst_tester.move(3, 32'h0000_0001);
        i_bst_tester.shift(n, di, q);
        i_bst_tester.move(2, 32'h0000_0001);
    endtask : dr_scan
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        tick(20000);
        $display("ERROR %0t timeout", $time);
        n_mismatch++;
        wrap_up();
    end
    initial
    begin
        i_rst = 1'b1;
        {cval, coe, pin} = '0;
        tick(8);
        i_rst = 1'b0;
        rnd_core();
        tick(4);
        chk(32'({tdo_oe, act}), 32'h0000_0000, "reset outputs");
        chk(32'({pout, poe}), 32'({cval, coe}), "reset pads");
        $display("test reset done");
        i_bst_tester.move(1, 32'h0000_0000);
        ir_load(`BST_IR_SAMPLE, `BST_IR_IDCODE);
        rnd_core();
        seed = xs(seed);
        din = seed;
        dr_scan(2 * CL, din, d);
        chk(32'(d[CL-1:0]), 32'(cap_exp(cval, coe, pin)), "capture");
        chk(32'(d[2*CL-1:CL]), 32'(din[CL-1:0]), "shift through");
        chk(32'({pout, poe}), 32'({cval, coe}), "sample pads");
        $display("test sample done");
        ir_load(`BST_IR_EXTEST, `BST_IR_SAMPLE);
        tick(4);
        chk(32'({pout, poe}), 32'(upd_exp(din[2*CL-1:CL])), "preload on pads");
        $display("test extest done");
        rnd_core();
        i_bst_tester.move(5, 32'h0000_001F);
        tick(4);
        chk(32'(act), 32'h0000_0000, "tms reset");
        chk(32'({pout, poe}), 32'({cval, coe}), "pads after tms reset");
        $display("test tms reset done");
        i_bst_tester.move(1, 32'h0000_0000);
        ir_load(`BST_IR_BYPASS, `BST_IR_IDCODE);
        seed = xs(seed);
        din = seed;
        dr_scan(16, din, d);
        chk(32'(d[15:1]), 32'(din[14:0]), "bypass path");
        chk(32'(d[0]), 32'h0000_0000, "bypass capture");
        $display("test bypass done");
        wrap_up();
    end
endmodule : tb
bind bst_tap bst_tap_properties #(.NPINS(NPINS)) i_bst_tap_properties (.i_clk(i_clk),
    .i_rst(i_rst), .i_tck(i_tck), .i_tms(i_tms), .i_core_output_value(i_core_output_value),
    .i_core_output_enable(i_core_output_enable), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
    .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe), .o_test_active(o_test_active));
`default_nettype wire
